// ### common/asmp_pkg.sv
// Constants and types shared by the asynchronous multiprocessor serial port.
//
// What this block does
// RQ1 - Words written to the transmit buffer move to the shifter and leave bit by bit.
// RQ2 - Received characters are copied to the receive buffer and the debug mirror.
// RQ3 - Transmitter and receiver run separately or together, neither depending on the other.
// RQ4 - Frame: start, data, address bit in address mode, optional parity, one or two stops.
// RQ5 - Character length field bits 2..0 selects one to eight data bits.
// RQ6 - Format bit 5 enables parity generation and checking.
// RQ7 - Format bit 6 selects odd parity when 0, even parity when 1.
// RQ8 - Format bit 7 selects one or two transmitted stop bits.
// RQ9 - Format bit 3 selects the protocol; zero means idle-line mode.
// RQ10 - While asleep, no ready flag, interrupt or error until an address frame.
// RQ11 - Only software writes change the sleep bit.
// RQ12 - Software compares block addresses and clears sleep on a match.
// RQ13 - First frame of a block wakes the port and requests an enabled interrupt.
// RQ14 - Idle-line mode: ten or more high bit times mark the next frame as address.
// RQ15 - Bit time for idle measurement comes from the programmed baud divisor.
// RQ16 - A delaying sender leaves at least ten idle bit times between blocks.
// RQ17 - Idle-line mode: a write with wake request set sends exactly eleven idle bit times instead.
// RQ18 - Software sets wake request, writes a dummy word, then the address word.
// RQ19 - Wake temporary flag captures wake request at shifter load; request then clears.
// RQ20 - Receive status bit 1 holds the receive wake flag.
// RQ21 - Address mode: address bit follows data, one in first frame, else zero.
// RQ22 - Address mode: the transmitter sends the wake temporary flag as address bit.
// RQ23 - Eight sample periods per bit; majority of periods four, five and six.
// RQ24 - Start bit accepted after four low samples; any high sample restarts search.
// RQ25 - The transmit pin idles high whenever no frame is shifting out.
`default_nettype none
package asmp_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int BAUD_W = 16;
  // Register byte offsets.
  localparam logic [7:0] OFS_FFC = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_CTL2 = 8'h0C;
  localparam logic [7:0] OFS_RXST = 8'h10;
  localparam logic [7:0] OFS_EMU = 8'h14;
  localparam logic [7:0] OFS_RXBUF = 8'h18;
  localparam logic [7:0] OFS_TXBUF = 8'h1C;
  // Field positions.
  localparam int FFC_LEN_MSB = 2;
  localparam int FFC_MODE = 3;
  localparam int FFC_PAR_EN = 5;
  localparam int FFC_PAR_EVEN = 6;
  localparam int FFC_STOP2 = 7;
  localparam int C1_RX_EN = 0;
  localparam int C1_TX_EN = 1;
  localparam int C1_SLEEP = 2;
  localparam int C1_TX_WAKE_REQUEST = 3;
  localparam int C2_TX_IE = 0;
  localparam int C2_RX_IE = 1;
  localparam int C2_TX_EMPTY = 6;
  localparam int C2_TX_READY = 7;
  localparam int ST_WAKE = 1;
  localparam int ST_PE = 2;
  localparam int ST_OE = 3;
  localparam int ST_FE = 4;
  localparam int ST_RDY = 6;
  localparam int ST_ERR = 7;
  // Reset values.
  localparam logic [7:0] FFC_RST = 8'h07;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0000;
  // Bit timing in sample periods.
  localparam int SAMPLES_PER_BIT = 8;
  localparam logic [2:0] BIT_LAST = 3'(SAMPLES_PER_BIT - 1);
  localparam int START_LOW_COUNT = 4;
  localparam logic [2:0] LOW_LAST = 3'(START_LOW_COUNT - 1);
  localparam logic [2:0] START_PHASE = 3'(START_LOW_COUNT);
  localparam logic [2:0] VOTE_FIRST = 3'h3;
  localparam logic [2:0] VOTE_LAST = 3'h5;
  localparam logic [2:0] CHAR_MAX_IDX = 3'h7;
  localparam int IDLE_BLOCK_BITS = 10;
  localparam int WAKE_IDLE_BITS = 11;
  localparam logic [6:0] IDLE_BLOCK_TICKS = 7'(IDLE_BLOCK_BITS * SAMPLES_PER_BIT);
  localparam logic [3:0] WAKE_LAST = 4'(WAKE_IDLE_BITS - 1);
  typedef enum logic [6:0] {
    TX_IDLE = 7'h01,
    TX_START = 7'h02,
    TX_DATA = 7'h04,
    TX_PARITY = 7'h08,
    TX_ADDR = 7'h10,
    TX_STOP = 7'h20,
    TX_WIDLE = 7'h40
  } asmp_tx_state_t;
  typedef enum logic [5:0] {
    RX_SEARCH = 6'h01,
    RX_START = 6'h02,
    RX_DATA = 6'h04,
    RX_PARITY = 6'h08,
    RX_ADDR = 6'h10,
    RX_STOP = 6'h20
  } asmp_rx_state_t;
endpackage : asmp_pkg
`default_nettype wire

// ### hw/asmp_port.sv
// Asynchronous serial port with multiprocessor wake-up and a Wishbone slave.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module asmp_port (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [asmp_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [asmp_pkg::DAT_W-1:0] wb_dat_i,
  output logic [asmp_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic tx_irq,
  output logic rx_irq
);
  import asmp_pkg::*;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
    logic [7:0] ffc;
    logic rx_en;
    logic tx_en;
    logic sleep;
    logic tx_wake_request;
    logic [BAUD_W-1:0] baud;
    logic tx_ie;
    logic rx_ie;
    logic [7:0] txbuf;
    logic txfull;
    asmp_tx_state_t tst;
    logic [7:0] tsh;
    logic wake_temp_flag;
    logic [2:0] tsc;
    logic [3:0] tbit;
    logic tx_pin;
    logic sync1;
    logic sync2;
    asmp_rx_state_t rst;
    logic [2:0] rsc;
    logic [2:0] lowc;
    logic [2:0] rbit;
    logic [2:0] vote;
    logic [7:0] rsh;
    logic rpar;
    logic rpe;
    logic raddr;
    logic blk;
    logic [6:0] idlec;
    logic [7:0] rxbuf;
    logic [7:0] rxemu;
    logic rx_ready_flag;
    logic wake;
    logic pe;
    logic oe;
    logic fe;
    logic tx_irq;
    logic rx_irq;
  } asmp_state_t;

  localparam asmp_state_t ST_RESET = '{
    ffc: FFC_RST,
    baud: BAUD_RST,
    tst: TX_IDLE,
    rst: RX_SEARCH,
    tx_pin: 1'b1,
    sync1: 1'b1,
    sync2: 1'b1,
    default: '0
  };

  asmp_state_t st_reg;
  asmp_state_t st_next;
  logic tick;
  logic commit;
  logic wr;
  logic rd_buf;
  logic [DAT_W-1:0] rd_val;
  logic [2:0] len;
  logic [7:0] mask;
  logic txpar;
  logic tx_load;
  logic bit_end;
  logic rb;
  logic addr_frame;
  logic accept;

  // --------------------------------------------------------------------
  // Sample clock
  // --------------------------------------------------------------------
  asmp_tick_gen u_tick (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .divisor(st_reg.baud),
    .tick(tick)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    len = st_reg.ffc[FFC_LEN_MSB:0]; // [RQ5]
    mask = 8'hFF >> (CHAR_MAX_IDX - len);
    txpar = (^(st_reg.tsh & mask)) ^ ~st_reg.ffc[FFC_PAR_EVEN]; // [RQ7]
    commit = wb_cyc_i & wb_stb_i & st_reg.ack;
    wr = commit & wb_we_i;
    rd_buf = commit & ~wb_we_i & (wb_adr_i == OFS_RXBUF);
    bit_end = st_reg.rsc == BIT_LAST;
    rb = (st_reg.vote[0] & st_reg.vote[1]) | (st_reg.vote[0] & st_reg.vote[2])
      | (st_reg.vote[1] & st_reg.vote[2]); // [RQ23]
    addr_frame = st_reg.ffc[FFC_MODE] ? st_reg.raddr : st_reg.blk; // [RQ9]
    accept = 1'b0;
    tx_load = st_reg.tst == TX_IDLE && st_reg.tx_en && st_reg.txfull; // [RQ3]

    // Bus answer and read data.
    rd_val = '0;
    case (wb_adr_i)
      OFS_FFC: rd_val[7:0] = st_reg.ffc;
      OFS_CTL1: begin
        rd_val[C1_RX_EN] = st_reg.rx_en;
        rd_val[C1_TX_EN] = st_reg.tx_en;
        rd_val[C1_SLEEP] = st_reg.sleep;
        rd_val[C1_TX_WAKE_REQUEST] = st_reg.tx_wake_request;
      end
      OFS_BAUD: rd_val[BAUD_W-1:0] = st_reg.baud;
      OFS_CTL2: begin
        rd_val[C2_TX_IE] = st_reg.tx_ie;
        rd_val[C2_RX_IE] = st_reg.rx_ie;
        rd_val[C2_TX_EMPTY] = ~st_reg.txfull & (st_reg.tst == TX_IDLE);
        rd_val[C2_TX_READY] = ~st_reg.txfull;
      end
      OFS_RXST: begin
        rd_val[ST_WAKE] = st_reg.wake; // [RQ20]
        rd_val[ST_PE] = st_reg.pe;
        rd_val[ST_OE] = st_reg.oe;
        rd_val[ST_FE] = st_reg.fe;
        rd_val[ST_RDY] = st_reg.rx_ready_flag;
        rd_val[ST_ERR] = st_reg.pe | st_reg.oe | st_reg.fe;
      end
      OFS_EMU: rd_val[7:0] = st_reg.rxemu;
      OFS_RXBUF: rd_val[7:0] = st_reg.rxbuf;
      OFS_TXBUF: rd_val[7:0] = st_reg.txbuf;
      default: rd_val = '0;
    endcase
    st_next.ack = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    st_next.dat = st_next.ack ? rd_val : '0;

    // Reading the receive buffer clears ready and errors, but keeps overrun if a frame is accepted in the same cycle; new events win.
    if (rd_buf) begin
      st_next.rx_ready_flag = 1'b0;
      st_next.pe = 1'b0;
      st_next.oe = 1'b0;
      st_next.fe = 1'b0;
    end

    // Receive input synchroniser.
    st_next.sync1 = serial_in_pin;
    st_next.sync2 = st_reg.sync1;

    // Receiver.
    if (tick) begin
      if (st_reg.rst != RX_SEARCH) begin
        st_next.rsc = st_reg.rsc + 3'h1;
        if (st_reg.rsc >= VOTE_FIRST && st_reg.rsc <= VOTE_LAST) begin
          st_next.vote = {st_reg.vote[1:0], st_reg.sync2}; // [RQ23]
        end
      end
      case (st_reg.rst)
        RX_SEARCH: begin
          if (!st_reg.sync2) begin
            st_next.idlec = '0;
            if (st_reg.lowc == LOW_LAST) begin
              st_next.rst = RX_START; // [RQ24]
              st_next.rsc = START_PHASE;
              st_next.lowc = '0;
              st_next.rsh = '0;
              st_next.rpar = 1'b0;
              st_next.rpe = 1'b0;
              st_next.raddr = 1'b0;
            end else begin
              st_next.lowc = st_reg.lowc + 3'h1;
            end
          end else begin
            st_next.lowc = '0; // [RQ24]
            if (st_reg.idlec != IDLE_BLOCK_TICKS) begin
              st_next.idlec = st_reg.idlec + 7'h01; // [RQ15]
            end
            if (st_reg.idlec == IDLE_BLOCK_TICKS - 7'h01) begin
              st_next.blk = 1'b1; // [RQ14]
            end
          end
        end
        RX_START: begin
          if (bit_end) begin
            st_next.rst = RX_DATA;
            st_next.rbit = '0;
          end
        end
        RX_DATA: begin
          if (bit_end) begin
            st_next.rsh[st_reg.rbit] = rb; // [RQ2]
            st_next.rpar = st_reg.rpar ^ rb;
            st_next.rbit = st_reg.rbit + 3'h1;
            if (st_reg.rbit == len) begin
              if (st_reg.ffc[FFC_MODE]) begin
                st_next.rst = RX_ADDR; // [RQ21]
              end else if (st_reg.ffc[FFC_PAR_EN]) begin
                st_next.rst = RX_PARITY; // [RQ6]
              end else begin
                st_next.rst = RX_STOP;
              end
            end
          end
        end
        RX_PARITY: begin
          if (bit_end) begin
            st_next.rpe = (st_reg.rpar ^ rb) == st_reg.ffc[FFC_PAR_EVEN]; // [RQ7]
            st_next.rst = RX_STOP;
          end
        end
        RX_ADDR: begin
          if (bit_end) begin
            st_next.raddr = rb; // [RQ21]
            st_next.rst = st_reg.ffc[FFC_PAR_EN] ? RX_PARITY : RX_STOP;
          end
        end
        RX_STOP: begin
          if (bit_end) begin
            st_next.rst = RX_SEARCH;
            st_next.blk = 1'b0;
            st_next.idlec = '0;
            accept = st_reg.rx_en & (~st_reg.sleep | addr_frame); // [RQ10]
            if (accept) begin
              st_next.rxbuf = st_reg.rsh; // [RQ2]
              st_next.rxemu = st_reg.rsh;
              st_next.oe = st_reg.oe | (st_reg.rx_ready_flag & ~rd_buf);
              st_next.rx_ready_flag = 1'b1; // [RQ13]
              st_next.pe = st_next.pe | st_reg.rpe;
              st_next.fe = st_next.fe | ~rb;
              st_next.wake = addr_frame; // [RQ20]
            end
          end
        end
        default: st_next.rst = RX_SEARCH;
      endcase
    end

    // Transmitter.
    if (tx_load) begin
      st_next.tsh = st_reg.txbuf; // [RQ1]
      st_next.wake_temp_flag = st_reg.tx_wake_request; // [RQ19]
      st_next.tx_wake_request = 1'b0;
      st_next.txfull = 1'b0;
      st_next.tsc = '0;
      st_next.tbit = '0;
      st_next.tst = (st_reg.tx_wake_request && !st_reg.ffc[FFC_MODE]) ? TX_WIDLE : TX_START; // [RQ17]
    end else if (tick && st_reg.tst != TX_IDLE) begin
      st_next.tsc = st_reg.tsc + 3'h1;
      if (st_reg.tsc == BIT_LAST) begin
        st_next.tbit = st_reg.tbit + 4'h1;
        case (st_reg.tst)
          TX_START: begin
            st_next.tst = TX_DATA; // [RQ4]
            st_next.tbit = '0;
          end
          TX_DATA: begin
            if (st_reg.tbit == {1'b0, len}) begin
              st_next.tbit = '0;
              if (st_reg.ffc[FFC_MODE]) begin
                st_next.tst = TX_ADDR; // [RQ21]
              end else if (st_reg.ffc[FFC_PAR_EN]) begin
                st_next.tst = TX_PARITY; // [RQ6]
              end else begin
                st_next.tst = TX_STOP;
              end
            end
          end
          TX_PARITY: begin
            st_next.tbit = '0;
            st_next.tst = TX_STOP;
          end
          TX_ADDR: begin
            st_next.tbit = '0;
            st_next.tst = st_reg.ffc[FFC_PAR_EN] ? TX_PARITY : TX_STOP;
          end
          TX_STOP: begin
            if (!(st_reg.ffc[FFC_STOP2] && st_reg.tbit == 4'h0)) begin
              st_next.tst = TX_IDLE; // [RQ8]
            end
          end
          TX_WIDLE: begin
            if (st_reg.tbit == WAKE_LAST) begin
              st_next.tst = TX_IDLE; // [RQ17]
            end
          end
          default: st_next.tst = TX_IDLE;
        endcase
      end
    end
    case (st_reg.tst)
      TX_START: st_next.tx_pin = 1'b0;
      TX_DATA: st_next.tx_pin = st_reg.tsh[st_reg.tbit[2:0]]; // [RQ1]
      TX_PARITY: st_next.tx_pin = txpar; // [RQ6]
      TX_ADDR: st_next.tx_pin = st_reg.wake_temp_flag; // [RQ22]
      default: st_next.tx_pin = 1'b1; // [RQ25]
    endcase

    // Register writes; a software write wins over a hardware clear.
    if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        OFS_FFC: st_next.ffc = wb_dat_i[7:0];
        OFS_CTL1: begin
          st_next.rx_en = wb_dat_i[C1_RX_EN]; // [RQ3]
          st_next.tx_en = wb_dat_i[C1_TX_EN];
          st_next.sleep = wb_dat_i[C1_SLEEP]; // [RQ11]
          st_next.tx_wake_request = wb_dat_i[C1_TX_WAKE_REQUEST];
        end
        OFS_BAUD: st_next.baud[7:0] = wb_dat_i[7:0];
        OFS_CTL2: begin
          st_next.tx_ie = wb_dat_i[C2_TX_IE];
          st_next.rx_ie = wb_dat_i[C2_RX_IE]; // [RQ13]
        end
        OFS_TXBUF: begin
          st_next.txbuf = wb_dat_i[7:0];
          st_next.txfull = 1'b1;
        end
        default: st_next.txfull = st_next.txfull;
      endcase
    end
    if (wr && wb_sel_i[1] && wb_adr_i == OFS_BAUD) begin
      st_next.baud[BAUD_W-1:8] = wb_dat_i[BAUD_W-1:8];
    end

    st_next.tx_irq = st_next.tx_ie & ~st_next.txfull;
    st_next.rx_irq = st_next.rx_ie & st_next.rx_ready_flag; // [RQ13]
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;
  assign serial_out_pin = st_reg.tx_pin;
  assign tx_irq = st_reg.tx_irq;
  assign rx_irq = st_reg.rx_irq;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  logic wr_ctl1;
  assign wr_ctl1 = wr & wb_sel_i[0] & (wb_adr_i == OFS_CTL1);

  AST_WB_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_TX_IDLE_HIGH: assert property (st_reg.tst == TX_IDLE |=> serial_out_pin) // [RQ25]
    else $error("transmit pin low while idle");
  AST_TX_START_LOW: assert property (st_reg.tst == TX_START |=> !serial_out_pin) // [RQ1]
    else $error("start bit not low");
  AST_WAKE_IDLE_HIGH: assert property (st_reg.tst == TX_WIDLE |=> serial_out_pin) // [RQ17]
    else $error("wake idle period not high");
  AST_WUT_LOAD: assert property (tx_load |=> st_reg.wake_temp_flag == $past(st_reg.tx_wake_request)
    && (!st_reg.tx_wake_request || $past(wr_ctl1))) // [RQ19]
    else $error("wake temporary not captured or request not cleared");
  AST_SLEEP_CPU_ONLY: assert property ($changed(st_reg.sleep) |-> $past(wr_ctl1)) // [RQ11]
    else $error("sleep changed without a software write");
  AST_SLEEP_GATES: assert property ($rose(st_reg.rx_ready_flag) |-> !$past(st_reg.sleep)
    || st_reg.wake) // [RQ10]
    else $error("ready set while asleep on a data frame");
  AST_MIRROR: assert property ($rose(st_reg.rx_ready_flag) |-> st_reg.rxbuf == st_reg.rxemu) // [RQ2]
    else $error("mirror differs from receive buffer");
  AST_START_FOUR: assert property (st_reg.rst == RX_SEARCH ##1 st_reg.rst == RX_START
    |-> $past(st_reg.lowc) == LOW_LAST && !$past(st_reg.sync2)) // [RQ24]
    else $error("start accepted without four low samples");
  AST_IDLE_BLOCK: assert property ($rose(st_reg.blk) |-> st_reg.idlec == IDLE_BLOCK_TICKS) // [RQ14]
    else $error("block start flagged before ten idle bits");
endmodule : asmp_port
`default_nettype wire

// ### hw/asmp_tick_gen.sv
// Sample clock tick generator driven by the baud divisor.
`timescale 1ns/1ns
`default_nettype none
module asmp_tick_gen (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [asmp_pkg::BAUD_W-1:0] divisor,
  output logic tick
);
  import asmp_pkg::*;

  typedef struct packed {
    logic [BAUD_W-1:0] cnt;
    logic tick;
  } asmp_tick_state_t;

  asmp_tick_state_t st_reg;
  asmp_tick_state_t st_next;

  // One tick every divisor plus one clocks.
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt >= divisor) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule : asmp_tick_gen
`default_nettype wire

// ### tb/asmp_port_tb.sv
// Self-checking bench for the multiprocessor serial port.
`timescale 1ns/1ns
`default_nettype none
module asmp_port_tb;
  import asmp_pkg::*;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [DAT_W-1:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, serial_in_pin, serial_out_pin, tx_irq, rx_irq;
  logic [31:0] seed = 32'h7BB4;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  always #20 ref_clk = ~ref_clk;
  asmp_port u_asmp_port (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .tx_irq(tx_irq),
    .rx_irq(rx_irq));
  asmp_remote u_asmp_remote (.ref_clk(ref_clk), .line_in(serial_out_pin),
    .line_out(serial_in_pin));
  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] rnd();
    logic [31:0] x;
    x = seed ^ (seed << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    seed = x;
    return x;
  endfunction : rnd
  function automatic logic [7:0] mask(input logic [7:0] f, input logic [7:0] d);
    return d & 8'((9'h002 << f[2:0]) - 9'h001);
  endfunction : mask
  // Builds the bits after the start bit: data, address bit, parity, stops.
  function automatic logic [15:0] frame(input logic [7:0] f, input logic [7:0] d,
                                        input logic a, output int n);
    logic [15:0] v;
    logic [7:0] m;
    v = 16'hFFFF;
    m = mask(f, d);
    n = 0;
    for (int i = 0; i <= int'(f[2:0]); i++) begin
      v[n] = m[i];
      n++;
    end
    if (f[3]) begin
      v[n] = a;
      n++;
    end
    if (f[5]) begin
      v[n] = f[6] ? ^m : ~^m;
      n++;
    end
    n = n + (f[7] ? 2 : 1);
    return v;
  endfunction : frame
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int w;
    w = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge ref_clk);
      w++;
    end while (wb_ack_o !== 1'h1 && w < 50);
    if (w >= 50) begin
      n_errors++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, adr, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] adr, output logic [31:0] q);
    wb(1'h0, adr, 32'h0, q);
  endtask : rd
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    logic [31:0] q, d;
    logic [7:0] f;
    logic [15:0] fv, got;
    logic wk, bad;
    int n, m;
    time t0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    check(serial_out_pin, 1'h1);
    rd(OFS_FFC, q);
    check(q, 32'(FFC_RST));
    rd(8'h40, q);
    check(q, 32'h0);
    wr(OFS_BAUD, 32'h0);
    for (int k = 0; k < 10; k++) begin
      d = rnd();
      f = {d[15:13], 1'h0, d[11:8]};
      wk = d[11] & d[16];
      bad = d[13] & d[17];
      wr(OFS_FFC, 32'(f));
      wr(OFS_CTL1, 32'({wk, 3'h3}));
      fv = frame(f, d[7:0], wk, n);
      fork
        wr(OFS_TXBUF, {24'h0, d[7:0]});
        u_asmp_remote.capture(n, got);
        u_asmp_remote.send(fv ^ (16'(bad) << (int'(f[2:0]) + 1 + int'(f[3]))), n);
      join
      check(got, fv);
      rd(OFS_CTL1, q);
      check(q, 32'h3);
      rd(OFS_RXST, q);
      check(q[ST_PE], bad);
      check(q[ST_RDY], 1'h1);
      rd(OFS_EMU, q);
      check(q, 32'(mask(f, d[7:0])));
      rd(OFS_RXBUF, q);
      check(q, 32'(mask(f, d[7:0])));
    end
    wr(OFS_FFC, 32'h0F);
    wr(OFS_CTL2, 32'h3);
    wr(OFS_CTL1, 32'h7);
    check(tx_irq, 1'h1);
    for (int k = 0; k < 3; k++) begin
      d = {24'h0, 8'(k * 8'h3C + 8'h21)};
      fv = frame(8'h0F, d[7:0], k == 1, n);
      if (k == 2) begin
        wr(OFS_CTL1, 32'h3);
      end
      u_asmp_remote.send(fv ^ (16'(k == 0) << 9), n);
      repeat (8) @(posedge ref_clk);
      check(rx_irq, k != 0);
      rd(OFS_RXST, q);
      check(q[ST_RDY], k != 0);
      check(q[ST_ERR], 1'h0);
      if (k != 0) begin
        check(q[ST_WAKE], k == 1);
        rd(OFS_CTL1, q);
        check(q[C1_SLEEP], k == 1);
        rd(OFS_RXBUF, q);
        check(q, d);
      end
    end
    wr(OFS_FFC, 32'h07);
    wr(OFS_CTL1, 32'h7);
    for (int k = 0; k < 3; k++) begin
      if (k != 1) begin
        repeat (96) @(posedge ref_clk);
      end
      d = {24'h0, 8'(k * 8'h11 + 8'h11)};
      fv = frame(8'h07, d[7:0], 1'h0, n);
      u_asmp_remote.send(fv, n);
      repeat (8) @(posedge ref_clk);
      rd(OFS_RXST, q);
      check(q[ST_RDY], k != 1);
      rd(OFS_RXBUF, q);
      check(q, k != 1 ? d : 32'h11);
    end
    wr(OFS_CTL1, 32'hB);
    wr(OFS_TXBUF, 32'hFF);
    t0 = $time;
    fv = frame(8'h07, 8'h5C, 1'h0, n);
    fork
      wr(OFS_TXBUF, 32'h5C);
      u_asmp_remote.capture(n, got);
    join
    m = int'((u_asmp_remote.t_fall - t0) / 40);
    check(32'(m >= 90 && m <= 98), 32'h1);
    check(got, fv);
    wrap_up();
  end
endmodule : asmp_port_tb
`default_nettype wire

// ### tb/asmp_remote.sv
// Far-side serial station that sends and captures frames for the port bench.
`timescale 1ns/1ns
`default_nettype none
module asmp_remote (
  input wire logic ref_clk,
  input wire logic line_in,
  output logic line_out
);
  time t_fall;
  initial begin
    line_out = 1'h1;
    t_fall = 0;
  end
  // Sends a start bit, then n bits LSB first, eight clocks each; the line idles high.
  task automatic send(input logic [15:0] v, input int n);
    @(posedge ref_clk);
    line_out <= 1'h0;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      line_out <= v[i];
      repeat (8) @(posedge ref_clk);
    end
    line_out <= 1'h1;
  endtask : send
  // Waits for a start bit, then samples n bits in the middle of each bit.
  task automatic capture(input int n, output logic [15:0] v);
    int w;
    w = 0;
    v = '1;
    while (line_in !== 1'h0 && w < 4000) begin
      @(posedge ref_clk);
      w++;
    end
    t_fall = $time;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge ref_clk);
      v[i] = line_in;
    end
  endtask : capture
endmodule : asmp_remote
`default_nettype wire
